// ==== verilog/qpd_pkg.sv ====
// constants, types and register map of the quadrature position decoder
//
// Overview of operation
// [R1] count first channel or both channels
// [R2] optional index pulse resets position counter
// [R3] phase inputs or step plus direction
// [R4] optional swap of channels before decoding
// [R5] max position bounds counter; reverse index loads
// [R6] direction readable, held while stationary
// [R7] error set when both inputs change together in phase mode
// [R8] configure first; decode only while enabled
// [R9] per-event enable gates interrupt output
// [R10] four event flags in one field
// [R11] clear mask write deasserts selected flags
// [R12] raw and masked status both readable
// [R13] position count readable at any time
// [R14] software writes position; counting continues there
// [R15] velocity capture only while position enabled
// [R16] events: index, timer, direction change, error
// [R17] inputs synchronised; all state set to its reset value on reset
package qpd_pkg;

   // -------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] QPD_OFF_CTRL   = 8'h00; // configuration
   localparam logic [7:0] QPD_OFF_MAXPOS = 8'h04; // max_position_value
   localparam logic [7:0] QPD_OFF_POS    = 8'h08; // position count
   localparam logic [7:0] QPD_OFF_STAT   = 8'h0c; // direction, error
   localparam logic [7:0] QPD_OFF_VPER   = 8'h10; // velocity period
   localparam logic [7:0] QPD_OFF_VLAST  = 8'h14; // last period count
   localparam logic [7:0] QPD_OFF_VACC   = 8'h18; // running count
   localparam logic [7:0] QPD_OFF_RIS    = 8'h1c; // raw event status
   localparam logic [7:0] QPD_OFF_IEN    = 8'h20; // event enables
   localparam logic [7:0] QPD_OFF_ICLR   = 8'h24; // event clear, wo
   localparam logic [7:0] QPD_OFF_MIS    = 8'h28; // masked status

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int QPD_EVT_ERR   = 0; // phase_error_event
   localparam int QPD_EVT_DIR   = 1; // direction_change_event
   localparam int QPD_EVT_TIMER = 2; // velocity_timer_event
   localparam int QPD_EVT_INDEX = 3; // index_detect_event
   localparam int QPD_STAT_DIR  = 0; // 1 = forward
   localparam int QPD_STAT_ERR  = 1; // sticky phase error

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [31:0] QPD_RST_MAXPOS = 32'hffffffff;
   localparam logic [31:0] QPD_RST_VPER   = 32'h00000001;
   localparam logic        QPD_RST_DIR    = 1'b1;

   // configuration word, low bits of the control register
   typedef struct packed {
      logic vel_enable;         // bit 5
      logic inputs_swapped;     // bit 4
      logic step_direction_mode;// bit 3
      logic reset_on_index;     // bit 2
      logic count_both_channels;// bit 1
      logic enable;             // bit 0
   } qpd_ctrl_t;

   // synchronised encoder pins
   typedef struct packed {
      logic index;
      logic second;
      logic first;
   } qpd_pins_t;

endpackage

// ==== verilog/qpd_top.sv ====
// quadrature position decoder with apb register slave
`timescale 1ns/1ps
module qpd_top
   import qpd_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // encoder pins
   input  wire logic        channel_first,
   input  wire logic        channel_second,
   input  wire logic        index_in,
   // interrupt
   output logic             irq
);

   // -------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   // two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   qpd_ctrl_t   ctrl_reg;
   qpd_pins_t   pin_meta_reg;
   qpd_pins_t   pin_sync_reg;
   logic        a_prev_reg;
   logic        b_prev_reg;
   logic        idx_prev_reg;
   logic [31:0] max_reg;
   logic [31:0] pos_reg;
   logic [31:0] pos_next;
   logic        dir_reg;
   logic        err_reg;
   logic [31:0] vper_reg;
   logic [31:0] vtim_reg;
   logic [31:0] vacc_reg;
   logic [31:0] vlast_reg;
   logic [3:0]  ris_reg;
   logic [3:0]  ris_next;
   logic [3:0]  ien_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        irq_reg;

   // -------------------------------------------------------------
   // apb decode
   // -------------------------------------------------------------
   wire        apb_req  = psel & penable & ~pready_reg;
   wire        apb_done = psel & penable & pready_reg;
   wire        wr_done  = apb_done & pwrite;
   wire        hit_ctrl = paddr == QPD_OFF_CTRL;
   wire        hit_max  = paddr == QPD_OFF_MAXPOS;
   wire        hit_pos  = paddr == QPD_OFF_POS;
   wire        hit_stat = paddr == QPD_OFF_STAT;
   wire        hit_vper = paddr == QPD_OFF_VPER;
   wire        hit_vlst = paddr == QPD_OFF_VLAST;
   wire        hit_vacc = paddr == QPD_OFF_VACC;
   wire        hit_ris  = paddr == QPD_OFF_RIS;
   wire        hit_ien  = paddr == QPD_OFF_IEN;
   wire        hit_iclr = paddr == QPD_OFF_ICLR;
   wire        hit_mis  = paddr == QPD_OFF_MIS;
   wire        hit_any  = hit_ctrl | hit_max | hit_pos | hit_stat
                        | hit_vper | hit_vlst | hit_vacc | hit_ris
                        | hit_ien | hit_iclr | hit_mis;
   wire        pos_wr   = wr_done & hit_pos;
   wire        iclr_wr  = wr_done & hit_iclr;
   wire        stat_wr  = wr_done & hit_stat;
   wire [3:0]  mis      = ris_reg & ien_reg;                     // R12
   wire [3:0]  ien_next = (wr_done & hit_ien) ? pwdata[3:0] : ien_reg;

   // read data selection; write-only clear reads as zero
   wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_reg}
      : hit_max  ? max_reg
      : hit_pos  ? pos_reg                                        // R13
      : hit_stat ? {30'h0, err_reg, dir_reg}                      // R6
      : hit_vper ? vper_reg
      : hit_vlst ? vlast_reg
      : hit_vacc ? vacc_reg
      : hit_ris  ? {28'h0000000, ris_reg}                         // R12
      : hit_ien  ? {28'h0000000, ien_reg}
      : hit_mis  ? {28'h0000000, mis}                             // R12
      : 32'h00000000;

   // -------------------------------------------------------------
   // input capture and decoding
   // -------------------------------------------------------------
   // two-flop synchronisers on the encoder pins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_reg <= '0;                                      // R17
         pin_sync_reg <= '0;
      end
      else
      begin
         pin_meta_reg <= {index_in, channel_second, channel_first};
         pin_sync_reg <= pin_meta_reg;                            // R17
      end
   end

   // channel exchange ahead of any decoding
   wire a_in = ctrl_reg.inputs_swapped ? pin_sync_reg.second
                                       : pin_sync_reg.first;     // R4
   wire b_in = ctrl_reg.inputs_swapped ? pin_sync_reg.first
                                       : pin_sync_reg.second;    // R4
   wire run   = ctrl_reg.enable;                                 // R8
   wire a_chg = run & (a_in ^ a_prev_reg);
   wire b_chg = run & (b_in ^ b_prev_reg);
   wire sdir  = ctrl_reg.step_direction_mode;
   wire both  = ctrl_reg.count_both_channels;

   // phase mode: one channel alone moves; step mode: clock edges
   wire ph_step = (a_chg & ~b_chg) | (both & b_chg & ~a_chg);    // R1
   wire sd_step = a_chg & (a_in | both);                          // R1
   wire step    = sdir ? sd_step : ph_step;                       // R3
   wire ph_fwd  = a_chg ? (a_in != b_in) : (a_in == b_in);
   wire fwd     = sdir ? ~b_in : ph_fwd;                          // R3
   wire ph_err  = ~sdir & a_chg & b_chg;                          // R7
   wire dir_now = step ? fwd : dir_reg;
   wire idx_hit = run & pin_sync_reg.index & ~idx_prev_reg;
   wire dir_chg = step & (fwd != dir_reg);

   // -------------------------------------------------------------
   // position counter
   // -------------------------------------------------------------
   wire [31:0] pos_inc = (pos_reg == max_reg) ? 32'h00000000
                                              : pos_reg + 32'h1;
   wire [31:0] pos_dec = (pos_reg == 32'h0) ? max_reg
                                            : pos_reg - 32'h1;

   // software load first, then index alignment, then counting
   always_comb
   begin
      pos_next = pos_reg;
      if (pos_wr)
         pos_next = pwdata;                                       // R14
      else if (idx_hit & ctrl_reg.reset_on_index)                 // R2
         pos_next = dir_now ? 32'h00000000 : max_reg;             // R5
      else if (step)
         pos_next = fwd ? pos_inc : pos_dec;                      // R5
   end

   // decoder state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         a_prev_reg   <= 1'b0;
         b_prev_reg   <= 1'b0;
         idx_prev_reg <= 1'b0;
         pos_reg      <= 32'h00000000;                            // R17
         dir_reg      <= QPD_RST_DIR;
         err_reg      <= 1'b0;
      end
      else
      begin
         a_prev_reg   <= a_in;
         b_prev_reg   <= b_in;
         idx_prev_reg <= pin_sync_reg.index;
         pos_reg      <= pos_next;
         dir_reg      <= dir_now;                                 // R6
         err_reg      <= ph_err | (err_reg
                         & ~(stat_wr & pwdata[QPD_STAT_ERR]));    // R7
      end
   end

   // -------------------------------------------------------------
   // velocity capture
   // -------------------------------------------------------------
   wire vel_on  = run & ctrl_reg.vel_enable;                      // R15
   wire vel_exp = vel_on & (vtim_reg >= vper_reg - 32'h1);
   wire [31:0] vacc_step = vacc_reg + {31'h0, step};

   // pulse count over each timer period
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vtim_reg  <= 32'h00000000;
         vacc_reg  <= 32'h00000000;
         vlast_reg <= 32'h00000000;
      end
      else if (!vel_on)
      begin
         vtim_reg <= 32'h00000000;                                // R15
         vacc_reg <= 32'h00000000;
      end
      else if (vel_exp)
      begin
         vtim_reg  <= 32'h00000000;
         vacc_reg  <= 32'h00000000;
         vlast_reg <= vacc_step;
      end
      else
      begin
         vtim_reg <= vtim_reg + 32'h1;
         vacc_reg <= vacc_step;                                   // R1
      end
   end

   // -------------------------------------------------------------
   // events and interrupt
   // -------------------------------------------------------------
   wire [3:0] evt;
   assign evt[QPD_EVT_ERR]   = ph_err;                            // R16
   assign evt[QPD_EVT_DIR]   = dir_chg;                           // R16
   assign evt[QPD_EVT_TIMER] = vel_exp;                           // R16
   assign evt[QPD_EVT_INDEX] = idx_hit;                           // R16
   wire [3:0] clr_mask = iclr_wr ? pwdata[3:0] : 4'h0;

   // new events win over a clear in the same cycle
   assign ris_next = evt | (ris_reg & ~clr_mask);                 // R11

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ris_reg <= 4'h0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ris_reg <= ris_next;                                     // R10
         irq_reg <= |(ris_next & ien_next);                       // R9
      end
   end

   // -------------------------------------------------------------
   // configuration registers and bus answer
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg <= '0;
         max_reg  <= QPD_RST_MAXPOS;
         vper_reg <= QPD_RST_VPER;
         ien_reg  <= 4'h0;
      end
      else if (wr_done)
      begin
         if (hit_ctrl)
            ctrl_reg <= pwdata[5:0];                              // R8
         if (hit_max)
            max_reg <= pwdata;                                    // R5
         if (hit_vper)
            vper_reg <= pwdata;
         if (hit_ien)
            ien_reg <= pwdata[3:0];                               // R9
      end
   end

   // one wait state; data and error ready with pready
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end
      else
      begin
         pready_reg  <= apb_req;
         pslverr_reg <= apb_req & ~hit_any;
         prdata_reg  <= (apb_req & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq     = irq_reg;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_disabled_hold: assert property (!run && !pos_wr |=> // R8
      $stable(pos_reg))
      else $error("position moved while disabled");
   chk_both_change: assert property (ph_err |=> err_reg && ris_reg[0]) // R7
      else $error("simultaneous change not flagged");
   chk_irq_gate: assert property (irq == (|mis)) // R9
      else $error("interrupt differs from enabled events");
   chk_clear_flags: assert property (iclr_wr && evt == 4'h0 |=> // R11
      (ris_reg & $past(pwdata[3:0])) == 4'h0)
      else $error("cleared flag still set");
   chk_index_reverse: assert property (idx_hit && ctrl_reg.reset_on_index // R5
      && !pos_wr && !dir_now |=> pos_reg == $past(max_reg))
      else $error("reverse index did not load max");
   chk_pos_load: assert property (pos_wr |=> pos_reg == $past(pwdata)) // R14
      else $error("position write lost");
   chk_dir_hold: assert property (!step |=> $stable(dir_reg)) // R6
      else $error("direction changed while stationary");
   chk_vel_off: assert property (!vel_on |=> vacc_reg == 32'h0 // R15
      && !ris_reg[2] || $past(ris_reg[2]))
      else $error("velocity ran while off");
   chk_dir_event: assert property (dir_chg |=> ris_reg[1]) // R16
      else $error("direction change not flagged");

   cov_index_reset: cover property (idx_hit && ctrl_reg.reset_on_index);
   cov_phase_error: cover property (ph_err);
   cov_timer_irq:   cover property (vel_exp ##1 irq);

endmodule // qpd_top

// ==== sim/qpd_encoder_model.sv ====
// encoder partner model: phase pairs, step pulses and index pulses
`timescale 1ns/1ps
module qpd_encoder_model
(
   // clock and command from the bench
   input  wire logic       clk,
   input  wire logic       req,
   input  wire logic [2:0] cmd,
   // encoder pins
   output logic            first,
   output logic            second,
   output logic            index
);
   int hold = 0;
   logic step_cmd;

   // step commands pulse the first pin after setting direction
   assign step_cmd = cmd[2] && (cmd[1] != cmd[0]);

   initial
   begin
      first = 1'b0;
      second = 1'b0;
      index = 1'b0;
   end

   // one move per request; pins then stand for several clocks
   always @(posedge clk)
   begin
      if (hold > 0)
         hold <= hold - 1;
      if (req)
      begin
         hold <= 8;
         case (cmd)
            3'd1: {first, second} <= {~second, first};
            3'd2: {first, second} <= {second, ~first};
            3'd3: {first, second} <= {~first, ~second};
            3'd4: index <= 1'b1;
            3'd5: second <= 1'b0;
            3'd6: second <= 1'b1;
            default: ;
         endcase
      end
      if (hold == 5 && step_cmd)
         first <= 1'b1;
      if (hold == 1)
      begin
         index <= 1'b0;
         if (step_cmd)
            first <= 1'b0;
      end
   end
endmodule // qpd_encoder_model

// ==== sim/qpd_top_tb.sv ====
// self-checking bench for the quadrature position decoder
`timescale 1ns/1ps
module qpd_top_tb;
   import qpd_pkg::*;
   localparam logic [31:0] MAXP = 32'h00000064;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, irq, ch_a, ch_b, idx;
   logic        req = 1'b0;
   logic [2:0]  cmd = 3'd0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, pos_e, rnd;
   logic [32:0] q[$];
   int          n_errors = 0, n_checks = 0, cyc = 0;

   always #2 clk = ~clk;

   qpd_top dut_u (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .channel_first(ch_a), .channel_second(ch_b), .index_in(idx),
      .irq(irq));
   qpd_encoder_model enc_u (.clk(clk), .req(req), .cmd(cmd),
      .first(ch_a), .second(ch_b), .index(idx));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t read exp %h got %h", $time, e, g);
      end
   endtask

   task automatic chk_irq(input logic e);
      @(negedge clk);
      n_checks++;
      if (irq !== e)
      begin
         n_errors++;
         $display("ERROR %0t irq exp %b got %b", $time, e, irq);
      end
      @(posedge clk);
   endtask

   // one apb transfer; expected answer noted for the monitor
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      q.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask

   // encoder moves; d is the counted step per move
   task automatic mv(input logic [2:0] c, input int n, input int d);
      repeat (n)
      begin
         req <= 1'b1;
         cmd <= c;
         @(posedge clk);
         req <= 1'b0;
         repeat (14) @(posedge clk);
         if (d > 0)
            pos_e = (pos_e == MAXP) ? 32'h0 : pos_e + 32'h1;
         if (d < 0)
            pos_e = (pos_e == 32'h0) ? MAXP : pos_e - 32'h1;
      end
   endtask

   // completed transfers compared against the oldest note
   always @(posedge clk)
      if (psel && penable && pready === 1'b1)
         chk_rd(q.pop_front(), {pslverr, prdata});

   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         n_errors++;
         $display("ERROR %0t timeout", $time);
         stop_test();
      end
   end

   initial
   begin
      rnd = lfsr(32'h70d13d18);
      pos_e = 32'd10 + {26'h0, rnd[5:0]};
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(QPD_OFF_CTRL, 32'h0);
      rd(QPD_OFF_MAXPOS, QPD_RST_MAXPOS);
      rd(QPD_OFF_STAT, 32'h1);
      rd(QPD_OFF_RIS, 32'h0);
      apb(1'b0, 8'h2c, 32'h0, 33'h100000000);
      $display("test reset done");
      wr(QPD_OFF_MAXPOS, MAXP);
      wr(QPD_OFF_POS, pos_e);
      rd(QPD_OFF_POS, pos_e);
      wr(QPD_OFF_CTRL, 32'h1);
      mv(3'd1, 4, 0);
      pos_e = pos_e + 32'h2;
      rd(QPD_OFF_POS, pos_e);
      wr(QPD_OFF_CTRL, 32'h3);
      mv(3'd1, 4, 1);
      rd(QPD_OFF_POS, pos_e);
      mv(3'd2, 2, -1);
      rd(QPD_OFF_POS, pos_e);
      rd(QPD_OFF_STAT, 32'h0);
      rd(QPD_OFF_RIS, 32'h2);
      $display("test counting done");
      wr(QPD_OFF_CTRL, 32'h13);
      mv(3'd2, 0, 0);
      mv(3'd1, 2, -1);
      rd(QPD_OFF_POS, pos_e);
      mv(3'd3, 1, 0);
      rd(QPD_OFF_POS, pos_e);
      rd(QPD_OFF_RIS, 32'h3);
      wr(QPD_OFF_CTRL, 32'h12);
      mv(3'd1, 2, 0);
      rd(QPD_OFF_POS, pos_e);
      $display("test swap error disable done");
      wr(QPD_OFF_CTRL, 32'h7);
      mv(3'd1, 1, 1);
      mv(3'd4, 1, 0);
      pos_e = 32'h0;
      rd(QPD_OFF_POS, pos_e);
      mv(3'd1, 2, 1);
      mv(3'd2, 1, -1);
      mv(3'd4, 1, 0);
      pos_e = MAXP;
      rd(QPD_OFF_POS, pos_e);
      mv(3'd2, 2, -1);
      wr(QPD_OFF_CTRL, 32'h9);
      mv(3'd5, 3, 1);
      rd(QPD_OFF_POS, pos_e);
      mv(3'd6, 1, -1);
      rd(QPD_OFF_POS, pos_e);
      rd(QPD_OFF_STAT, 32'h2);
      rd(QPD_OFF_RIS, 32'hb);
      wr(QPD_OFF_CTRL, 32'hb);
      mv(3'd5, 1, 1);
      pos_e = pos_e + 32'h1;
      rd(QPD_OFF_POS, pos_e);
      $display("test index step done");
      wr(QPD_OFF_ICLR, 32'hf);
      wr(QPD_OFF_VPER, 32'h8);
      rd(QPD_OFF_VPER, 32'h8);
      wr(QPD_OFF_CTRL, 32'h20);
      repeat (20) @(posedge clk);
      rd(QPD_OFF_RIS, 32'h0);
      wr(QPD_OFF_CTRL, 32'h21);
      repeat (20) @(posedge clk);
      wr(QPD_OFF_CTRL, 32'h0);
      rd(QPD_OFF_RIS, 32'h4);
      chk_irq(1'b0);
      wr(QPD_OFF_IEN, 32'hb);
      chk_irq(1'b0);
      rd(QPD_OFF_MIS, 32'h0);
      wr(QPD_OFF_IEN, 32'h4);
      chk_irq(1'b1);
      rd(QPD_OFF_MIS, 32'h4);
      wr(QPD_OFF_ICLR, 32'h4);
      chk_irq(1'b0);
      rd(QPD_OFF_RIS, 32'h0);
      rd(QPD_OFF_ICLR, 32'h0);
      wr(QPD_OFF_STAT, 32'h2);
      rd(QPD_OFF_STAT, 32'h1);
      $display("test timer interrupt done");
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(QPD_OFF_POS, 32'h0);
      rd(QPD_OFF_MAXPOS, QPD_RST_MAXPOS);
      rd(QPD_OFF_IEN, 32'h0);
      chk_irq(1'b0);
      $display("test reset again done");
      if (q.size() != 0)
      begin
         n_errors++;
         $display("ERROR %0t unanswered transfers", $time);
      end
      stop_test();
   end
endmodule // qpd_top_tb
